/* rtl/fps_pkg.sv */
// Shared constants and types for the fetch, pc and stack sequencer
package fps_pkg;

  // Widths and depths
  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int CNT_W = 4;
  localparam int PHASES = 4;

  // Vectors and reset values
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] INT_VECTOR = 12'h004;
  localparam logic [3:0] PHASE_RESET = 4'h1;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] IR_RESET = 16'h0000;

  // Instruction word fields
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int FN_MSB = 11;
  localparam int FN_LSB = 8;
  localparam int IMM_MSB = 7;
  localparam int IMM_LSB = 0;
  localparam int TGT_MSB = 11;

  // Opcodes
  localparam logic [3:0] OPC_ALU = 4'h0;
  localparam logic [3:0] OPC_JUMP = 4'h1;
  localparam logic [3:0] OPC_CALL = 4'h2;
  localparam logic [3:0] OPC_RET = 4'h3;
  localparam logic [3:0] OPC_INTERRUPT_RETURN_INSTR = 4'h4;
  localparam logic [3:0] OPC_SKZ = 4'h5;
  localparam logic [3:0] OPC_SKNZ = 4'h6;
  localparam logic [3:0] OPC_PCL = 4'h7;
  localparam logic [3:0] OPC_EXT = 4'h8;

  // Status flag positions
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_OV = 2;

  // Register offsets
  localparam logic [7:0] REG_PCL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_ACC = 8'h02;
  localparam logic [7:0] REG_SEQ = 8'h03;

  // Sequencer status fields
  localparam int SEQ_CNT_LSB = 0;
  localparam int SEQ_INT_BIT = 4;
  localparam int SEQ_FULL_BIT = 5;
  localparam int SEQ_EXT_BIT = 6;
  localparam int SEQ_DUMMY_BIT = 7;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL,
    ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_PASS, ALU_NOP
  } fps_alu_fn_t;

  typedef enum logic {
    SEQ_RUN,
    SEQ_EXT_WAIT
  } fps_seq_t;

endpackage

/* rtl/fps_core_if.sv */
// Interface joining the sequencer to its return stack and ALU
`timescale 1ns/1ns
interface fps_core_if;
  logic push;
  logic pop;
  logic [11:0] push_pc;
  logic [11:0] top_pc;
  logic full;
  logic [3:0] count;
  fps_pkg::fps_alu_fn_t alu_fn;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic alu_cin;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_z;
  logic alu_ov;
  logic alu_c_en;
  logic alu_z_en;
  logic alu_ov_en;

  modport seq (
    output push, pop, push_pc, alu_fn, alu_a, alu_b, alu_cin,
    input top_pc, full, count, alu_y, alu_c, alu_z, alu_ov,
    input alu_c_en, alu_z_en, alu_ov_en
  );
  modport stack (
    input push, pop, push_pc,
    output top_pc, full, count
  );
  modport alu (
    input alu_fn, alu_a, alu_b, alu_cin,
    output alu_y, alu_c, alu_z, alu_ov, alu_c_en, alu_z_en, alu_ov_en
  );
endinterface

/* rtl/fps_return_stack.sv */
// Eight-level hidden return stack for program counter values
`timescale 1ns/1ns
module fps_return_stack (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Sequencer side
  fps_core_if.stack st
);
  logic [11:0] mem [fps_pkg::STACK_DEPTH];
  logic [2:0] wr_ptr;
  logic [3:0] count;
  wire logic [2:0] top_ptr = wr_ptr - 3'h1;
  wire logic is_full = (count == 4'(fps_pkg::STACK_DEPTH));

  assign st.top_pc = mem[top_ptr]; // RULE12
  assign st.full = is_full;
  assign st.count = count;

  // Circular store: a push when full overwrites the oldest entry
  always_ff @(posedge clk)
  begin
    if (st.push)
      mem[wr_ptr] <= st.push_pc; // RULE15
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= 3'h0; // RULE13
      count <= 4'h0;
    end
    else if (st.push)
    begin
      wr_ptr <= wr_ptr + 3'h1;
      count <= is_full ? count : count + 4'h1; // RULE15
    end
    else if (st.pop && count != 4'h0)
    begin
      wr_ptr <= top_ptr;
      count <= count - 4'h1;
    end
  end
endmodule

/* rtl/fps_alu.sv */
// Eight-bit ALU with status flag results
`timescale 1ns/1ns
module fps_alu (
  // Sequencer side
  fps_core_if.alu al
);
  logic [8:0] sum;
  logic [7:0] addend;
  logic [7:0] y;

  // RULE16
  always_comb
  begin
    sum = 9'h000;
    addend = al.alu_b;
    y = al.alu_a;
    al.alu_c = al.alu_cin;
    al.alu_c_en = 1'b0;
    al.alu_z_en = 1'b1;
    al.alu_ov_en = 1'b0;
    case (al.alu_fn)
      fps_pkg::ALU_ADD, fps_pkg::ALU_ADC,
      fps_pkg::ALU_SUB, fps_pkg::ALU_SBC:
      begin
        // Subtract as add of inverse; carry set means no borrow
        addend = (al.alu_fn == fps_pkg::ALU_SUB ||
                  al.alu_fn == fps_pkg::ALU_SBC) ? ~al.alu_b : al.alu_b;
        sum = {1'b0, al.alu_a} + {1'b0, addend} + 9'(
          (al.alu_fn == fps_pkg::ALU_ADC || al.alu_fn == fps_pkg::ALU_SBC)
          ? al.alu_cin : (al.alu_fn == fps_pkg::ALU_SUB));
        y = sum[7:0];
        al.alu_c = sum[8]; // RULE17
        al.alu_c_en = 1'b1;
        al.alu_ov_en = 1'b1;
      end
      fps_pkg::ALU_AND: y = al.alu_a & al.alu_b;
      fps_pkg::ALU_OR: y = al.alu_a | al.alu_b;
      fps_pkg::ALU_XOR: y = al.alu_a ^ al.alu_b;
      fps_pkg::ALU_CPL: y = ~al.alu_a;
      fps_pkg::ALU_INC: y = al.alu_a + 8'h01;
      fps_pkg::ALU_DEC: y = al.alu_a - 8'h01;
      fps_pkg::ALU_RR:
      begin
        y = {al.alu_a[0], al.alu_a[7:1]};
        al.alu_z_en = 1'b0;
      end
      fps_pkg::ALU_RL:
      begin
        y = {al.alu_a[6:0], al.alu_a[7]};
        al.alu_z_en = 1'b0;
      end
      fps_pkg::ALU_RRC:
      begin
        y = {al.alu_cin, al.alu_a[7:1]};
        al.alu_c = al.alu_a[0];
        al.alu_c_en = 1'b1;
        al.alu_z_en = 1'b0;
      end
      fps_pkg::ALU_RLC:
      begin
        y = {al.alu_a[6:0], al.alu_cin};
        al.alu_c = al.alu_a[7];
        al.alu_c_en = 1'b1;
        al.alu_z_en = 1'b0;
      end
      fps_pkg::ALU_PASS:
      begin
        y = al.alu_b;
        al.alu_z_en = 1'b0;
      end
      default:
      begin
        y = al.alu_a;
        al.alu_z_en = 1'b0;
      end
    endcase
    al.alu_y = y;
    al.alu_z = (y == 8'h00);
    al.alu_ov = (al.alu_a[7] == addend[7]) && (y[7] != al.alu_a[7]);
  end
endmodule

/* rtl/fps_sequencer.sv */
// Four-phase fetch and execute sequencer with program counter and stack
// Notes on behaviour
// [RULE1] Four non-overlapping phases from clk; one ring pass is one cycle.
// [RULE2] PC advances at start of phase one; later phases decode and execute.
// [RULE3] Next word fetched while current executes; one per cycle normally.
// [RULE4] Standard one cycle, extended two; branches add one cycle more.
// [RULE5] PC-changing instructions take two cycles: get target, then branch.
// [RULE6] PC increments by one after each instruction unless it branches.
// [RULE7] PC is 12 bits: 4 upper plus 8 low; only low byte accessible.
// [RULE8] Jump, call, interrupt and reset load destination straight into PC.
// [RULE9] Taken skip discards prefetched word; a dummy cycle replaces it.
// [RULE10] Low byte read/write; write jumps within page plus dummy fetch.
// [RULE11] Eight-entry return stack; contents and pointer hidden from software.
// [RULE12] Call or interrupt acknowledge pushes PC; returns pop it back.
// [RULE13] Reset points the stack pointer at the top of the stack.
// [RULE14] Stack full: request recorded, acknowledge held until a return pops.
// [RULE15] Call with full stack still runs and loses the oldest entry.
// [RULE16] Eight-bit ALU does arithmetic, logic, rotate, inc, dec, decisions.
// [RULE17] ALU carry, borrow and other changes update the status flags.
// [RULE18] After reset PC holds the reset vector, address zero.
// [RULE19] PC increments wrap to zero within twelve bits.
// [RULE20] Withheld interrupt request stays set until actually serviced.
`timescale 1ns/1ns
module fps_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program memory fetch
  output logic [11:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  // Interrupt
  input wire logic int_req,
  output logic int_ack,
  output logic int_pending,
  // Phase clocks
  output logic [3:0] phase_clocks,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  fps_core_if core ();

  fps_return_stack u_stack (
    .clk(clk),
    .reset_n(reset_n),
    .st(core.stack)
  );

  fps_alu u_alu (
    .al(core.alu)
  );

  // State
  logic [11:0] pc;
  logic [15:0] exec_ir;
  logic exec_valid;
  fps_pkg::fps_seq_t seq_state;
  logic [7:0] acc;
  logic [7:0] status;
  logic int_flag;
  logic pcl_wr_pend;
  logic [7:0] pcl_wr_data;

  // Decode of the word in execution
  wire logic [3:0] opc = exec_ir[fps_pkg::OPC_MSB:fps_pkg::OPC_LSB];
  wire logic [3:0] fn = exec_ir[fps_pkg::FN_MSB:fps_pkg::FN_LSB];
  wire logic [7:0] imm = exec_ir[fps_pkg::IMM_MSB:fps_pkg::IMM_LSB];
  wire logic [11:0] target = exec_ir[fps_pkg::TGT_MSB:fps_pkg::IMM_LSB];
  wire logic is_alu = exec_valid && opc == fps_pkg::OPC_ALU;
  wire logic is_jump = exec_valid && opc == fps_pkg::OPC_JUMP;
  wire logic is_call = exec_valid && opc == fps_pkg::OPC_CALL;
  wire logic is_ret = exec_valid &&
    (opc == fps_pkg::OPC_RET || opc == fps_pkg::OPC_INTERRUPT_RETURN_INSTR);
  wire logic is_skz = exec_valid && opc == fps_pkg::OPC_SKZ;
  wire logic is_sknz = exec_valid && opc == fps_pkg::OPC_SKNZ;
  wire logic is_pcl = exec_valid && opc == fps_pkg::OPC_PCL;
  wire logic is_ext = exec_valid && opc == fps_pkg::OPC_EXT;

  // Instruction cycle ends on the last phase
  wire logic boundary = phase_clocks[fps_pkg::PHASES-1];

  // Extended word holds its place for one extra cycle
  wire logic ext_first = is_ext && seq_state == fps_pkg::SEQ_RUN; // RULE4

  // Branch decisions come from the ALU zero result
  wire logic skip_take = (is_skz && core.alu_z) ||
    (is_sknz && !core.alu_z); // RULE9
  wire logic branch_instr = is_jump || is_call || is_ret || is_pcl ||
    skip_take; // RULE5

  // Software low-byte write waits for a cycle free of own branches
  wire logic pcl_apply = pcl_wr_pend && !branch_instr && !ext_first;
  wire logic branch_any = branch_instr || pcl_apply;

  // Acknowledge only with room on the stack and no branch in flight
  wire logic int_take = int_flag && !core.full &&
    !branch_any && !ext_first; // RULE14

  wire logic [11:0] pc_inc = pc + 12'h001; // RULE19
  wire logic [11:0] page_jump_bus = {pc[11:8], pcl_wr_data}; // RULE10
  wire logic [11:0] page_jump_instr = {pc[11:8], imm};

  logic [11:0] next_pc;

  always_comb
  begin
    if (ext_first)
      next_pc = pc;
    else if (is_jump || is_call)
      next_pc = target; // RULE8
    else if (is_ret)
      next_pc = core.top_pc; // RULE12
    else if (is_pcl)
      next_pc = page_jump_instr; // RULE10
    else if (pcl_apply)
      next_pc = page_jump_bus; // RULE10
    else if (int_take)
      next_pc = fps_pkg::INT_VECTOR; // RULE8
    else
      next_pc = pc_inc; // RULE6
  end

  // Stack and ALU hookup
  assign core.push = boundary && (is_call || int_take); // RULE12
  assign core.pop = boundary && is_ret; // RULE12
  assign core.push_pc = pc;
  assign core.alu_fn = fps_pkg::fps_alu_fn_t'(fn);
  assign core.alu_a = acc;
  assign core.alu_b = imm;
  assign core.alu_cin = status[fps_pkg::ST_C];

  wire logic alu_commit = boundary && (is_alu || is_skz);

  logic [7:0] next_status;

  always_comb
  begin
    next_status = status;
    if (core.alu_c_en)
      next_status[fps_pkg::ST_C] = core.alu_c; // RULE17
    if (core.alu_z_en)
      next_status[fps_pkg::ST_Z] = core.alu_z; // RULE17
    if (core.alu_ov_en)
      next_status[fps_pkg::ST_OV] = core.alu_ov; // RULE17
  end

  // Phase ring, one-hot and never overlapping
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_clocks <= fps_pkg::PHASE_RESET;
    else
      phase_clocks <= {phase_clocks[2:0], phase_clocks[3]}; // RULE1
  end

  // Program counter moves at the edge that opens phase one
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pc <= fps_pkg::RESET_VECTOR; // RULE18
    else if (boundary)
      pc <= next_pc; // RULE2
  end

  // Fetched word enters execution unless flushed by a branch or an interrupt acknowledge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      exec_ir <= fps_pkg::IR_RESET;
      exec_valid <= 1'b0;
    end
    else if (boundary && !ext_first)
    begin
      exec_ir <= prog_rdata; // RULE3
      exec_valid <= !(branch_any || int_take); // RULE9
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      seq_state <= fps_pkg::SEQ_RUN;
    else if (boundary)
    begin
      case (seq_state)
        fps_pkg::SEQ_RUN:
          seq_state <= ext_first ? fps_pkg::SEQ_EXT_WAIT : fps_pkg::SEQ_RUN;
        fps_pkg::SEQ_EXT_WAIT:
          seq_state <= fps_pkg::SEQ_RUN; // RULE4
        default:
          seq_state <= fps_pkg::SEQ_RUN;
      endcase
    end
  end

  // Accumulator and flags commit at the end of execution
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc <= fps_pkg::ACC_RESET;
      status <= fps_pkg::STATUS_RESET;
    end
    else if (alu_commit)
    begin
      acc <= core.alu_y; // RULE16
      status <= next_status; // RULE17
    end
    else if (boundary && is_sknz)
      status <= next_status;
  end

  // Request flag: a new request beats the clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      int_flag <= 1'b0;
    else
      int_flag <= int_req || (int_flag && !(boundary && int_take)); // RULE20
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      int_ack <= 1'b0;
    else
      int_ack <= boundary && int_take; // RULE14
  end

  // Low-byte write from software; a fresh write beats the apply
  wire logic pcl_wr_hit = reg_wr && reg_addr == fps_pkg::REG_PCL;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcl_wr_pend <= 1'b0;
      pcl_wr_data <= 8'h00;
    end
    else
    begin
      pcl_wr_pend <= pcl_wr_hit || (pcl_wr_pend &&
        !(boundary && pcl_apply)); // RULE10
      if (pcl_wr_hit)
        pcl_wr_data <= reg_wdata;
    end
  end

  // Read side; stack contents and pointer are not mapped
  logic [7:0] seq_word;

  always_comb
  begin
    seq_word = 8'h00;
    seq_word[fps_pkg::SEQ_CNT_LSB +: fps_pkg::CNT_W] = core.count;
    seq_word[fps_pkg::SEQ_INT_BIT] = int_flag;
    seq_word[fps_pkg::SEQ_FULL_BIT] = core.full;
    seq_word[fps_pkg::SEQ_EXT_BIT] = seq_state == fps_pkg::SEQ_EXT_WAIT;
    seq_word[fps_pkg::SEQ_DUMMY_BIT] = !exec_valid;
  end

  logic [7:0] rd_sel;

  always_comb
  begin
    case (reg_addr)
      fps_pkg::REG_PCL: rd_sel = pc[7:0]; // RULE7
      fps_pkg::REG_STATUS: rd_sel = status;
      fps_pkg::REG_ACC: rd_sel = acc;
      fps_pkg::REG_SEQ: rd_sel = seq_word; // RULE11
      default: rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_sel;
    else
      reg_rdata <= 8'h00;
  end

  assign prog_addr = pc;
  assign int_pending = int_flag;

endmodule

/* verif/fps_prog_mem.sv */
// Behavioural program memory on the sequencer's fetch port
`timescale 1ns/1ns
module fps_prog_mem (
  // Fetch port
  input wire logic [11:0] prog_addr,
  output logic [15:0] prog_rdata
);
  logic [15:0] mem [0:4095];

  // Unused words are one-cycle no-ops, so stray fetches stay harmless
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 16'h9000;
  end

  assign prog_rdata = mem[prog_addr];
endmodule

/* verif/fps_sequencer_asserts.sv */
// Port-level checks for the sequencer
`timescale 1ns/1ns
module fps_sequencer_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program memory fetch
  input wire logic [11:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  // Interrupt
  input wire logic int_req,
  input wire logic int_ack,
  input wire logic int_pending,
  // Phase clocks
  input wire logic [3:0] phase_clocks,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Start only from sampled run state, so the release edge is not judged
  property p_phase_ring;
    reset_n |=> phase_clocks ==
      {$past(phase_clocks[2:0]), $past(phase_clocks[3])};
  endproperty
  a_phase_ring: assert property (p_phase_ring)
    else $error("phase ring did not rotate");

  // Fetch address may only move on the phase-four edge
  property p_addr_hold;
    !phase_clocks[3] |=> $stable(prog_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("fetch address moved mid-cycle");

  property p_reset_pc;
    $rose(reset_n) |-> prog_addr == fps_pkg::RESET_VECTOR &&
      phase_clocks == fps_pkg::PHASE_RESET;
  endproperty
  a_reset_pc: assert property (p_reset_pc)
    else $error("start address or phase wrong after reset");

  property p_ack_vector;
    int_ack |-> prog_addr == fps_pkg::INT_VECTOR;
  endproperty
  a_ack_vector: assert property (p_ack_vector)
    else $error("acknowledge without vector fetch");

  property p_ack_pulse;
    int_ack |-> !int_pending ##1 !int_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge not a single pulse");

  property p_req_flag;
    int_req |=> int_pending;
  endproperty
  a_req_flag: assert property (p_req_flag)
    else $error("request not recorded");

  property p_flag_clear;
    $fell(int_pending) |-> int_ack;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("request flag lost without service");

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");

  property p_pcl_read;
    reg_rd && reg_addr == fps_pkg::REG_PCL |=>
      reg_rdata == $past(prog_addr[7:0]);
  endproperty
  a_pcl_read: assert property (p_pcl_read)
    else $error("low byte read mismatch");
endmodule

bind fps_sequencer fps_sequencer_asserts fps_sequencer_asserts_inst (
  .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr),
  .prog_rdata(prog_rdata), .int_req(int_req), .int_ack(int_ack),
  .int_pending(int_pending), .phase_clocks(phase_clocks),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

/* verif/tb_fps_sequencer.sv */
// Self-checking bench for the fetch, pc and stack sequencer
`timescale 1ns/1ns
module tb_fps_sequencer;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic int_req = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [11:0] prog_addr;
  logic [15:0] prog_rdata;
  logic int_ack;
  logic int_pending;
  logic [3:0] phase_clocks;
  logic [7:0] reg_rdata;
  logic [7:0] rd;
  int n_errors = 0;
  int checked = 0;

  always #20 clk = ~clk;

  fps_sequencer fps_sequencer_inst (
    .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .int_req(int_req), .int_ack(int_ack),
    .int_pending(int_pending), .phase_clocks(phase_clocks),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  fps_prog_mem fps_prog_mem_inst (
    .prog_addr(prog_addr), .prog_rdata(prog_rdata)
  );

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timed_out;
    n_errors++;
    print_verdict();
  endtask

  // Leaves the bench just after the next instruction-cycle boundary
  task automatic sync;
    int i;
    for (i = 0; i < 8 && phase_clocks !== 4'h8; i++)
      @(posedge clk) #1;
    if (i == 8)
      timed_out();
    @(posedge clk) #1;
  endtask

  task automatic cyc(input logic [11:0] exp);
    sync();
    chk({4'h0, prog_addr}, {4'h0, exp});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse_int;
    @(posedge clk);
    int_req <= 1'b1;
    @(posedge clk);
    int_req <= 1'b0;
    #1;
  endtask

  task automatic wait_ack(input int n);
    int i;
    for (i = 0; i < n && int_ack !== 1'b1; i++)
      @(posedge clk) #1;
    if (i == n)
      timed_out();
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk({4'h0, prog_addr}, 16'h0000);
    chk({12'h0, phase_clocks}, 16'h0001);
  endtask

  task automatic t_branches;
    fps_prog_mem_inst.mem[12'h000] = 16'h1305;
    fps_prog_mem_inst.mem[12'h004] = 16'h4000;
    fps_prog_mem_inst.mem[12'h305] = 16'h23F0;
    fps_prog_mem_inst.mem[12'h3F0] = 16'h005A;
    fps_prog_mem_inst.mem[12'h3F1] = 16'h00B0;
    fps_prog_mem_inst.mem[12'h3F2] = 16'h3000;
    fps_prog_mem_inst.mem[12'h306] = 16'h64FF;
    fps_prog_mem_inst.mem[12'h307] = 16'h10FF;
    fps_prog_mem_inst.mem[12'h308] = 16'h7040;
    fps_prog_mem_inst.mem[12'h341] = 16'h8000;
    fps_prog_mem_inst.mem[12'h3A0] = 16'h23A0;
    do_reset();
    cyc(12'h001);
    cyc(12'h305);
    cyc(12'h306);
    cyc(12'h3F0);
    cyc(12'h3F1);
    cyc(12'h3F2);
    cyc(12'h3F3);
    cyc(12'h306);
    cyc(12'h307);
    cyc(12'h308);
    cyc(12'h309);
    cyc(12'h340);
    cyc(12'h341);
    cyc(12'h342);
    cyc(12'h342);
    cyc(12'h343);
  endtask

  task automatic t_regs;
    rd_reg(fps_pkg::REG_PCL, rd);
    chk({8'h0, rd}, 16'h0043);
    rd_reg(fps_pkg::REG_ACC, rd);
    chk({8'h0, rd}, 16'h000A);
    rd_reg(fps_pkg::REG_STATUS, rd);
    chk({13'h0, rd[2:0]}, 16'h0001);
    wr_reg(fps_pkg::REG_ACC, 8'hFF);
    rd_reg(fps_pkg::REG_ACC, rd);
    chk({8'h0, rd}, 16'h000A);
    rd_reg(8'h10, rd);
    chk({8'h0, rd}, 16'h0000);
  endtask

  task automatic t_interrupt;
    sync();
    wr_reg(fps_pkg::REG_PCL, 8'h80);
    cyc(12'h380);
    cyc(12'h381);
    pulse_int();
    chk({15'h0, int_pending}, 16'h0001);
    cyc(12'h004);
    wait_ack(3);
    chk({15'h0, int_pending}, 16'h0000);
    cyc(12'h005);
    cyc(12'h381);
    cyc(12'h382);
  endtask

  task automatic t_stack_full;
    sync();
    wr_reg(fps_pkg::REG_PCL, 8'hA0);
    cyc(12'h3A0);
    for (int k = 0; k < 8; k++)
    begin
      cyc(12'h3A1);
      cyc(12'h3A0);
    end
    pulse_int();
    rd_reg(fps_pkg::REG_SEQ, rd);
    chk({11'h0, rd[5], rd[3:0]}, 16'h0018);
    chk({4'h0, prog_addr}, 16'h03A1);
    cyc(12'h3A0);
    rd_reg(fps_pkg::REG_SEQ, rd);
    chk({12'h0, rd[3:0]}, 16'h0008);
    chk({15'h0, int_pending}, 16'h0001);
    // Turn the self-call into a return so the stack can drain
    fps_prog_mem_inst.mem[12'h3A0] = 16'h3000;
    wait_ack(16);
    chk({4'h0, prog_addr}, 16'h0004);
  endtask

  task automatic t_wrap;
    fps_prog_mem_inst.mem[12'h000] = 16'h1FFF;
    do_reset();
    rd_reg(fps_pkg::REG_SEQ, rd);
    chk({12'h0, rd[3:0]}, 16'h0000);
    cyc(12'h001);
    cyc(12'hFFF);
    cyc(12'h000);
  endtask

  initial
  begin
    #1;
    t_branches();
    t_regs();
    t_interrupt();
    t_stack_full();
    t_wrap();
    print_verdict();
  end
endmodule
